// [perf_regs.svh]
// Event codes, unit masks, reset values and sizes of the event counter.
`ifndef PERF_REGS_SVH
`define PERF_REGS_SVH

// ----------------------------------------------------------------------------
// Event codes and unit masks
// ----------------------------------------------------------------------------
`define EVT_BUBBLE_TWO 8'h98
`define EVT_DISPATCH_TOTAL 8'ha0
`define EVT_PORT_CYCLES 8'ha1
`define EVT_DECODE 8'haa
`define EVT_SP_SYNC 8'hab
`define MASK_NONE 8'h00
`define MASK_DECODED_ALL 8'h01
`define MASK_DECODED_COMPLEX 8'h08
`define MASK_SP_SYNC 8'h01
`define MASK_PORT_FIELD 8'h3f

// ----------------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------------
`define PORT_COUNT 6
`define DECODE_WIDTH 3
`define STEP_WIDTH 3
`define COUNT_WIDTH 40
`define SYNC_INFLIGHT_MAX 8
`define COUNT_RESET 40'h00_0000_0000
`define INFLIGHT_RESET 4'h0

`endif

// [perf_pkg.sv]
// Types shared by the event counter modules.
`default_nettype none
package perf_pkg;
   typedef logic [7:0] event_code_t;
   typedef enum logic [0:0] {
      SP_CLEAN = 1'b0,
      SP_DIRTY = 1'b1
   } sp_state_t;
endpackage
`default_nettype wire

// [perf_event_if.sv]
// Bundle of raw core events and the chosen step between counter and selector.
`default_nettype none
`include "perf_regs.svh"
interface perf_event_if;
   perf_pkg::event_code_t event_code;
   perf_pkg::event_code_t unit_mask;
   logic counter_zero;
   logic branches_close;
   logic target_unaligned;
   logic [`PORT_COUNT-1:0] port_dispatch;
   logic [`DECODE_WIDTH-1:0] decoded_count;
   logic complex_decoded;
   logic sp_sync;
   logic [`STEP_WIDTH-1:0] step;
   logic matched;
   logic unsupported;
   modport src (
      output event_code, unit_mask, counter_zero, branches_close, target_unaligned,
      output port_dispatch, decoded_count, complex_decoded, sp_sync,
      input step, matched, unsupported
   );
   modport sel (
      input event_code, unit_mask, counter_zero, branches_close, target_unaligned,
      input port_dispatch, decoded_count, complex_decoded, sp_sync,
      output step, matched, unsupported
   );
endinterface
`default_nettype wire

// [event_step_select.sv]
// Matches event code and unit mask and forms this cycle's counter step.
`default_nettype none
`include "perf_regs.svh"
module event_step_select (
   perf_event_if.sel ev
);
   // -------------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------------
   function automatic logic [`STEP_WIDTH-1:0] ones(input logic [`PORT_COUNT-1:0] v);
      logic [`STEP_WIDTH-1:0] n;
      n = '0;
      for (int i = 0; i < `PORT_COUNT; i++) begin
         n = n + `STEP_WIDTH'(v[i]);
      end
      return n;
   endfunction

   // -------------------------------------------------------------------------
   // Selection
   // -------------------------------------------------------------------------
   logic port_mask_ok;

   always_comb begin
      // Only a single port bit may be set, else no port is chosen.
      port_mask_ok = (ones(ev.unit_mask[`PORT_COUNT-1:0]) == `STEP_WIDTH'(1)) &&
                     ((ev.unit_mask & ~`MASK_PORT_FIELD) == `MASK_NONE);
      ev.step = '0;
      ev.matched = 1'b0;
      ev.unsupported = 1'b0;
      case (ev.event_code)
         `EVT_BUBBLE_TWO: begin
            if (ev.unit_mask == `MASK_NONE) begin
               ev.matched = 1'b1;
               ev.step = `STEP_WIDTH'(ev.branches_close | ev.target_unaligned);
            end
         end
         `EVT_DISPATCH_TOTAL: begin
            if (ev.unit_mask == `MASK_NONE) begin
               ev.matched = 1'b1;
               ev.step = ones(ev.port_dispatch);
            end
         end
         `EVT_PORT_CYCLES: begin
            // Other counters lack the per-port wiring, so they hold still.
            ev.unsupported = !ev.counter_zero;
            if (ev.counter_zero && port_mask_ok) begin
               ev.matched = 1'b1;
               ev.step = `STEP_WIDTH'(|(ev.port_dispatch &
                                       ev.unit_mask[`PORT_COUNT-1:0]));
            end
         end
         `EVT_DECODE: begin
            if (ev.unit_mask == `MASK_DECODED_ALL) begin
               ev.matched = 1'b1;
               ev.step = ev.decoded_count;
            end else if (ev.unit_mask == `MASK_DECODED_COMPLEX) begin
               ev.matched = 1'b1;
               ev.step = `STEP_WIDTH'(ev.complex_decoded);
            end
         end
         `EVT_SP_SYNC: begin
            if (ev.unit_mask == `MASK_SP_SYNC) begin
               ev.matched = 1'b1;
               ev.step = `STEP_WIDTH'(ev.sp_sync);
            end
         end
         default: begin
            ev.matched = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

// [perf_event_select_counter.sv]
// Top of the event selector and counter, with stack pointer sync tracking.
// ----------------------------------------------------------------------------
// How it works
// - Code 98h with mask 00h counts one kind of taken-branch bubble.
// - That bubble is raised for closely packed taken branches or an unaligned target.
// - Code a0h with mask 00h adds all micro-ops dispatched this cycle, up to six.
// - Code a1h counts dispatch cycles of the one port named by a one-hot mask.
// - Each port dispatches at most one micro-op a cycle, so that step is at most one.
// - Per-port dispatch counting works only on general counter zero.
// - Code aah with mask 01h counts every decoded instruction.
// - Code aah with mask 08h counts complex decodes, at most one a cycle.
// - Code abh with mask 01h counts explicit stack pointer use after implicit change.
// - Each sync inserts a micro-op held from rename until retirement.
// ----------------------------------------------------------------------------
`default_nettype none
`include "perf_regs.svh"
module perf_event_select_counter #(
   parameter int CNT_W = `COUNT_WIDTH,
   parameter int INFLIGHT_MAX = `SYNC_INFLIGHT_MAX
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] event_code_i,
   input wire logic [7:0] unit_mask_i,
   input wire logic counter_zero_i,
   input wire logic branches_close_i,
   input wire logic target_unaligned_i,
   input wire logic [`PORT_COUNT-1:0] port_dispatch_i,
   input wire logic [`DECODE_WIDTH-1:0] decoded_count_i,
   input wire logic complex_decoded_i,
   input wire logic sp_implicit_mod_i,
   input wire logic sp_explicit_addr_i,
   input wire logic sync_uop_retire_i,
   output logic [CNT_W-1:0] count_o,
   output logic unsupported_select_o,
   output logic sync_uop_insert_o,
   output logic [3:0] sync_uops_in_flight_o,
   output logic rename_stall_o
);
   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   if (CNT_W < 8 || CNT_W > `COUNT_WIDTH) begin : g_bad_width
      $error("Counter width out of range.");
   end
   if (INFLIGHT_MAX < 1 || INFLIGHT_MAX > 15) begin : g_bad_depth
      $error("In-flight limit out of range.");
   end

   // -------------------------------------------------------------------------
   // Reset release
   // -------------------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      perf_pkg::sp_state_t sp_state;
      logic [CNT_W-1:0] count;
      logic sync_insert;
      logic [3:0] inflight;
      logic unsupported;
   } state_t;

   state_t st;
   state_t next_st;
   logic sp_sync;
   logic full;

   perf_event_if ev ();

   assign ev.event_code = event_code_i;
   assign ev.unit_mask = unit_mask_i;
   assign ev.counter_zero = counter_zero_i;
   assign ev.branches_close = branches_close_i;
   assign ev.target_unaligned = target_unaligned_i;
   assign ev.port_dispatch = port_dispatch_i;
   assign ev.decoded_count = decoded_count_i;
   assign ev.complex_decoded = complex_decoded_i;
   assign ev.sp_sync = sp_sync;

   event_step_select u_sel (
      .ev(ev.sel)
   );

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   assign full = (st.inflight == 4'(INFLIGHT_MAX));
   // A sync waits for a free slot; the access is held back meanwhile.
   assign sp_sync = (st.sp_state == perf_pkg::SP_DIRTY) && sp_explicit_addr_i && !full;
   assign rename_stall_o = (st.sp_state == perf_pkg::SP_DIRTY) && sp_explicit_addr_i && full;

   always_comb begin
      next_st = st;
      next_st.count = st.count + CNT_W'(ev.step);
      next_st.unsupported = ev.unsupported;
      next_st.sync_insert = sp_sync;
      next_st.inflight = st.inflight + 4'(sp_sync) -
                         4'(sync_uop_retire_i && st.inflight != 4'h0);
      case (st.sp_state)
         perf_pkg::SP_CLEAN: begin
            if (sp_implicit_mod_i) begin
               next_st.sp_state = perf_pkg::SP_DIRTY;
            end
         end
         perf_pkg::SP_DIRTY: begin
            if (sp_sync && !sp_implicit_mod_i) begin
               next_st.sp_state = perf_pkg::SP_CLEAN;
            end
         end
         default: begin
            next_st.sp_state = perf_pkg::SP_CLEAN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st.sp_state <= perf_pkg::SP_CLEAN;
         st.count <= CNT_W'(`COUNT_RESET);
         st.sync_insert <= 1'b0;
         st.inflight <= `INFLIGHT_RESET;
         st.unsupported <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   assign count_o = st.count;
   assign unsupported_select_o = st.unsupported;
   assign sync_uop_insert_o = st.sync_insert;
   assign sync_uops_in_flight_o = st.inflight;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n);

   function automatic logic [2:0] pop6(input logic [`PORT_COUNT-1:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < `PORT_COUNT; i++) begin
         n = n + 3'(v[i]);
      end
      return n;
   endfunction

   sequence s_sp_dirtied;
      sp_implicit_mod_i;
   endsequence

   sequence s_sp_explicit;
      sp_explicit_addr_i && !full;
   endsequence

   a_sum_same_cycle: assert property (
      ##1 1'b1 |-> count_o == $past(count_o) + CNT_W'($past(ev.step)))
      else $error("Count did not take the summed step.");
   a_unmatched_holds: assert property (
      !ev.matched |=> count_o == $past(count_o))
      else $error("Count moved without a match.");
   a_bubble_step: assert property (
      event_code_i == `EVT_BUBBLE_TWO && unit_mask_i == `MASK_NONE
      && (branches_close_i || target_unaligned_i) |=> count_o == $past(count_o) + CNT_W'(1))
      else $error("Bubble did not add one.");
   a_bubble_cause: assert property (
      event_code_i == `EVT_BUBBLE_TWO && !branches_close_i && !target_unaligned_i
      |=> count_o == $past(count_o))
      else $error("Bubble counted without a cause.");
   a_dispatch_sum: assert property (
      event_code_i == `EVT_DISPATCH_TOTAL && unit_mask_i == `MASK_NONE
      |=> count_o == $past(count_o) + CNT_W'(pop6($past(port_dispatch_i))))
      else $error("Dispatch total wrong.");
   a_port_one: assert property (
      event_code_i == `EVT_PORT_CYCLES && counter_zero_i && unit_mask_i == 8'h01
      |=> count_o == $past(count_o) + CNT_W'($past(port_dispatch_i[0])))
      else $error("Port zero cycle count wrong.");
   a_port_step_max: assert property (
      event_code_i == `EVT_PORT_CYCLES |-> ev.step <= 3'h1)
      else $error("Port step above one.");
   a_port_zero_only: assert property (
      event_code_i == `EVT_PORT_CYCLES && !counter_zero_i
      |=> unsupported_select_o && count_o == $past(count_o))
      else $error("Port event counted off counter zero.");
   a_decode_all: assert property (
      event_code_i == `EVT_DECODE && unit_mask_i == `MASK_DECODED_ALL
      |=> count_o == $past(count_o) + CNT_W'($past(decoded_count_i)))
      else $error("Decode count wrong.");
   a_complex_step: assert property (
      event_code_i == `EVT_DECODE && unit_mask_i == `MASK_DECODED_COMPLEX
      |=> count_o - $past(count_o) <= CNT_W'(1))
      else $error("Complex step above one.");
   a_sync_insert: assert property (
      s_sp_dirtied ##1 s_sp_explicit |=> sync_uop_insert_o)
      else $error("Sync not inserted after implicit change.");
   a_sync_inflight: assert property (
      sp_sync && !sync_uop_retire_i |=> sync_uops_in_flight_o == $past(st.inflight) + 4'h1)
      else $error("Sync micro-op not held in flight.");
   // A slipped stall or a lost retire would wedge rename, so both ends of a slot are watched.
   a_stall_blocks_sync: assert property (
      rename_stall_o |=> !sync_uop_insert_o
      && sync_uops_in_flight_o <= $past(sync_uops_in_flight_o))
      else $error("Sync inserted while slots were full.");
   a_retire_frees: assert property (
      sync_uop_retire_i && !sp_sync && st.inflight != 4'h0
      |=> sync_uops_in_flight_o == $past(st.inflight) - 4'h1)
      else $error("Retired sync micro-op kept its slot.");
   a_sync_counted: assert property (
      event_code_i == `EVT_SP_SYNC && unit_mask_i == `MASK_SP_SYNC && sp_sync
      |=> count_o == $past(count_o) + CNT_W'(1))
      else $error("Sync not counted.");
   a_dispatch_max: assert property (
      event_code_i == `EVT_DISPATCH_TOTAL |-> ev.step <= 3'h6)
      else $error("Dispatch step above six.");
endmodule
`default_nettype wire

// [perf_event_select_counter_tb.sv]
// Self-checking testbench of the event selector and counter.
`default_nettype none
module perf_event_select_counter_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // -------------------------------------------------------------------------
   // Stimulus flags, packed as {zero, close, unaligned, complex, imp, expl, retire}
   // -------------------------------------------------------------------------
   localparam int cw = 40;
   localparam logic [6:0] f_cz = 7'h40, f_cl = 7'h20, f_un = 7'h10, f_cx = 7'h08;
   localparam logic [6:0] f_im = 7'h04, f_ex = 7'h02, f_rt = 7'h01;
   logic ref_clk_i = 1'b0, resetn_i = 1'b0;
   logic [7:0] event_code_i = 8'h00, unit_mask_i = 8'h00;
   logic counter_zero_i = 1'b0, branches_close_i = 1'b0, target_unaligned_i = 1'b0;
   logic [5:0] port_dispatch_i = 6'h00;
   logic [2:0] decoded_count_i = 3'h0;
   logic complex_decoded_i = 1'b0, sp_implicit_mod_i = 1'b0;
   logic sp_explicit_addr_i = 1'b0, sync_uop_retire_i = 1'b0;
   logic [cw-1:0] count_o, exp_cnt;
   logic unsupported_select_o, sync_uop_insert_o, rename_stall_o;
   logic [3:0] sync_uops_in_flight_o;
   int errors = 0, cmp_count = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   // The in-flight limit is cut to two so that the stall is reached in a few syncs.
   perf_event_select_counter #(.CNT_W(cw), .INFLIGHT_MAX(2)) dut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .event_code_i(event_code_i),
      .unit_mask_i(unit_mask_i), .counter_zero_i(counter_zero_i),
      .branches_close_i(branches_close_i), .target_unaligned_i(target_unaligned_i),
      .port_dispatch_i(port_dispatch_i), .decoded_count_i(decoded_count_i),
      .complex_decoded_i(complex_decoded_i), .sp_implicit_mod_i(sp_implicit_mod_i),
      .sp_explicit_addr_i(sp_explicit_addr_i), .sync_uop_retire_i(sync_uop_retire_i),
      .count_o(count_o), .unsupported_select_o(unsupported_select_o),
      .sync_uop_insert_o(sync_uop_insert_o), .sync_uops_in_flight_o(sync_uops_in_flight_o),
      .rename_stall_o(rename_stall_o));
   // -------------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------------
   task automatic check(input string name, input logic [cw-1:0] seen, input logic [cw-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Called right after a falling edge; every input is written once per time step.
   task automatic drv(input logic [7:0] c, input logic [7:0] m, input logic [5:0] p,
                      input logic [2:0] d, input logic [6:0] f);
      event_code_i = c;
      unit_mask_i = m;
      port_dispatch_i = p;
      decoded_count_i = d;
      {counter_zero_i, branches_close_i, target_unaligned_i, complex_decoded_i,
       sp_implicit_mod_i, sp_explicit_addr_i, sync_uop_retire_i} = f;
   endtask
   // One cycle: the step lands on the rising edge and is looked at on the next fall.
   task automatic cyc(input logic [cw-1:0] delta);
      @(negedge ref_clk_i);
      exp_cnt = exp_cnt + delta;
      check("count", count_o, exp_cnt);
   endtask
   // -------------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------------
   task automatic t_reset();
      check("count", count_o, '0);
      check("unsupported", {39'h0, unsupported_select_o}, 40'h0);
      check("insert", {39'h0, sync_uop_insert_o}, 40'h0);
      check("in_flight", {36'h0, sync_uops_in_flight_o}, 40'h0);
      check("stall", {39'h0, rename_stall_o}, 40'h0);
   endtask
   task automatic t_bubble();
      drv(8'h98, 8'h00, 6'h00, 3'h0, f_cl);
      cyc(40'h1);
      drv(8'h98, 8'h00, 6'h00, 3'h0, f_un);
      cyc(40'h1);
      drv(8'h98, 8'h00, 6'h00, 3'h0, f_cl | f_un);
      cyc(40'h1);
      drv(8'h98, 8'h01, 6'h00, 3'h0, f_cl);
      cyc(40'h0);
   endtask
   task automatic t_dispatch();
      drv(8'ha0, 8'h00, 6'h3f, 3'h0, 7'h00);
      cyc(40'h6);
      drv(8'ha0, 8'h00, 6'h05, 3'h0, 7'h00);
      cyc(40'h2);
      drv(8'ha0, 8'h01, 6'h3f, 3'h0, 7'h00);
      cyc(40'h0);
   endtask
   task automatic t_ports();
      for (int i = 0; i < 6; i++) begin
         drv(8'ha1, 8'h01 << i, 6'h3f, 3'h0, f_cz);
         cyc(40'h1);
         drv(8'ha1, 8'h01 << i, ~(6'h01 << i), 3'h0, f_cz);
         cyc(40'h0);
      end
      drv(8'ha1, 8'h03, 6'h3f, 3'h0, f_cz);
      cyc(40'h0);
      drv(8'ha1, 8'h01, 6'h3f, 3'h0, 7'h00);
      cyc(40'h0);
      check("unsupported", {39'h0, unsupported_select_o}, 40'h1);
      drv(8'h00, 8'h00, 6'h3f, 3'h0, f_cz);
      cyc(40'h0);
      check("unsupported", {39'h0, unsupported_select_o}, 40'h0);
   endtask
   task automatic t_decode();
      drv(8'haa, 8'h01, 6'h00, 3'h7, f_cx);
      cyc(40'h7);
      drv(8'haa, 8'h01, 6'h00, 3'h3, 7'h00);
      cyc(40'h3);
      drv(8'haa, 8'h08, 6'h00, 3'h7, f_cx);
      cyc(40'h1);
      drv(8'haa, 8'h08, 6'h00, 3'h7, 7'h00);
      cyc(40'h0);
      drv(8'haa, 8'h02, 6'h00, 3'h7, f_cx);
      cyc(40'h0);
   endtask
   task automatic t_sync();
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_im);
      cyc(40'h0);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex);
      cyc(40'h1);
      check("insert", {39'h0, sync_uop_insert_o}, 40'h1);
      check("in_flight", {36'h0, sync_uops_in_flight_o}, 40'h1);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex);
      cyc(40'h0);
      check("insert", {39'h0, sync_uop_insert_o}, 40'h0);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_im);
      cyc(40'h0);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex | f_im);
      cyc(40'h1);
      check("in_flight", {36'h0, sync_uops_in_flight_o}, 40'h2);
      // Still dirty, but both slots are taken, so the explicit access must wait.
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex);
      #5;
      check("stall", {39'h0, rename_stall_o}, 40'h1);
      cyc(40'h0);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex | f_rt);
      cyc(40'h0);
      check("in_flight", {36'h0, sync_uops_in_flight_o}, 40'h1);
      drv(8'hab, 8'h01, 6'h00, 3'h0, f_ex);
      cyc(40'h1);
      check("in_flight", {36'h0, sync_uops_in_flight_o}, 40'h2);
      drv(8'h00, 8'h00, 6'h00, 3'h0, 7'h00);
      cyc(40'h0);
   endtask
   // -------------------------------------------------------------------------
   // Main sequence and watchdog
   // -------------------------------------------------------------------------
   initial begin
      exp_cnt = '0;
      repeat (12) @(negedge ref_clk_i);
      t_reset();
      resetn_i = 1'b1;
      // The released reset passes two flops before inputs are counted.
      repeat (3) @(negedge ref_clk_i);
      t_bubble();
      t_dispatch();
      t_ports();
      t_decode();
      t_sync();
      give_verdict();
   end
   // The tests take under a hundred cycles; two thousand leaves ample margin.
   initial begin
      #(2000 * 50);
      errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
